// File: nfc_host.v
// NAND flash host controller: Avalon-MM slave driving the 8-bit NAND bus.
`timescale 1ns/10ps
`include "nfc_defs.vh"

module nfc_host (
  // Clock and reset
  input wire mclk_in,
  input wire nrst_in,
  // Avalon-MM slave
  input wire [3:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  output reg [31:0] avs_readdata_out,
  output reg avs_waitrequest_out,
  output reg irq_out,
  // NAND bus
  input wire [7:0] nand_io_in,
  output reg [7:0] nand_io_out,
  output reg nand_io_oe_out,
  output reg nand_cle_out,
  output reg nand_ale_out,
  output reg nand_ce_n_out,
  output reg nand_we_n_out,
  output reg nand_re_n_out,
  output reg nand_wp_n_out,
  input wire ready_busy_n_pin
);
  parameter STROBE_CYC = `NFC_STROBE_CYC;
  localparam TR_CYC = `NFC_TR_NS / `NFC_CLK_NS;
  localparam TSEQ_CYC = (`NFC_TSEQ_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS;
  localparam [9:0] ST_IDLE = 10'h001;
  localparam [9:0] ST_SETUP = 10'h002;
  localparam [9:0] ST_STROBE = 10'h004;
  localparam [9:0] ST_HOLD = 10'h008;
  localparam [9:0] ST_WAITRB = 10'h010;
  localparam [9:0] ST_RSTROBE = 10'h020;
  localparam [9:0] ST_RHOLD = 10'h040;
  localparam [9:0] ST_DONE = 10'h080;
  localparam [9:0] ST_ACK = 10'h100;
  localparam [9:0] ST_TR = 10'h200;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [9:0] state_r;
  reg [2:0] op_r;
  reg [7:0] byte_r;
  reg [7:0] rdata_r;
  reg [10:0] cnt_r;
  reg [2:0] irq_stat_r;
  reg [2:0] irq_mask_r;
  reg wp_en_r;
  reg standby_r;
  reg rb_q_r;
  reg refused_r;
  reg busy_wait_r;
  // A request is taken only while waitrequest is high, so a request still held at its acknowledge edge is not taken twice.
  wire acc = (avs_read_in | avs_write_in) & avs_waitrequest_out;
  wire rb_rise = ready_busy_n_pin & ~rb_q_r;
  wire [2:0] ev = {refused_r, state_r == ST_DONE, rb_rise};

  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      state_r <= ST_IDLE;
      op_r <= 3'h0;
      byte_r <= 8'h00;
      rdata_r <= 8'h00;
      cnt_r <= 11'h000;
      irq_stat_r <= 3'h0;
      irq_mask_r <= 3'h0;
      wp_en_r <= 1'b1;
      standby_r <= 1'b0;
      rb_q_r <= 1'b1;
      refused_r <= 1'b0;
      busy_wait_r <= 1'b0;
      avs_readdata_out <= 32'h0000_0000;
      avs_waitrequest_out <= 1'b1;
      irq_out <= 1'b0;
      nand_io_out <= 8'h00;
      nand_io_oe_out <= 1'b0;
      nand_cle_out <= 1'b0;
      nand_ale_out <= 1'b0;
      nand_ce_n_out <= 1'b1;
      nand_we_n_out <= 1'b1;
      nand_re_n_out <= 1'b1;
      nand_wp_n_out <= 1'b0;
    end else begin
      rb_q_r <= ready_busy_n_pin;
      refused_r <= 1'b0;
      avs_waitrequest_out <= 1'b1;
      if (avs_write_in && avs_waitrequest_out && state_r == ST_IDLE && avs_address_in == `NFC_REG_IRQ)
        irq_stat_r <= (irq_stat_r & ~avs_writedata_in[2:0]) | ev;
      else
        irq_stat_r <= irq_stat_r | ev;
      irq_out <= |(irq_stat_r & irq_mask_r);
      nand_wp_n_out <= ~wp_en_r;
      case (state_r)
        ST_IDLE: begin
          nand_ce_n_out <= standby_r;
          if (acc) begin
            state_r <= ST_ACK;
            case (avs_address_in)
              `NFC_REG_CTRL: begin
                if (avs_write_in) begin
                  wp_en_r <= avs_writedata_in[0];
                  standby_r <= avs_writedata_in[1];
                  busy_wait_r <= avs_writedata_in[2];
                end
                avs_readdata_out <= {29'h0, busy_wait_r, standby_r, wp_en_r};
              end
              `NFC_REG_CMD, `NFC_REG_ADDR, `NFC_REG_DATA: begin
                avs_readdata_out <= 32'h0000_0000;
                if (!ready_busy_n_pin && avs_address_in != `NFC_REG_CMD) begin
                  refused_r <= 1'b1;
                end else begin
                  op_r <= (avs_address_in == `NFC_REG_CMD) ? `NFC_OP_CMD :
                          (avs_address_in == `NFC_REG_ADDR) ? `NFC_OP_ADDR :
                          avs_write_in ? `NFC_OP_WDATA : `NFC_OP_RDATA;
                  byte_r <= avs_writedata_in[7:0];
                  nand_ce_n_out <= 1'b0;
                  state_r <= ST_SETUP;
                  cnt_r <= 11'h000;
                end
              end
              `NFC_REG_STAT: avs_readdata_out <= {23'h0, rdata_r, ready_busy_n_pin};
              `NFC_REG_IRQ: avs_readdata_out <= {29'h0, irq_stat_r};
              `NFC_REG_MASK: begin
                if (avs_write_in)
                  irq_mask_r <= avs_writedata_in[2:0];
                avs_readdata_out <= {29'h0, irq_mask_r};
              end
              `NFC_REG_CNT: avs_readdata_out <= {21'h0, 11'd`NFC_PAGE_BYTES};
              default: avs_readdata_out <= 32'h0000_0000;
            endcase
          end
        end
        ST_SETUP: begin
          nand_cle_out <= (op_r == `NFC_OP_CMD);
          nand_ale_out <= (op_r == `NFC_OP_ADDR);
          nand_io_out <= byte_r;
          nand_io_oe_out <= (op_r != `NFC_OP_RDATA);
          if (op_r == `NFC_OP_RDATA) begin
            state_r <= busy_wait_r ? ST_WAITRB : ST_RSTROBE;
            nand_re_n_out <= busy_wait_r;
          end else begin
            nand_we_n_out <= 1'b0;
            state_r <= ST_STROBE;
          end
        end
        ST_STROBE: begin
          cnt_r <= cnt_r + 11'h001;
          if (cnt_r == STROBE_CYC[10:0]) begin
            nand_we_n_out <= 1'b1;
            cnt_r <= 11'h000;
            state_r <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          cnt_r <= cnt_r + 11'h001;
          if (cnt_r == STROBE_CYC[10:0]) begin
            nand_cle_out <= 1'b0;
            nand_ale_out <= 1'b0;
            nand_io_oe_out <= 1'b0;
            // program, erase or resume then busy
            state_r <= ST_DONE;
          end
        end
        ST_WAITRB: begin
          cnt_r <= 11'h000;
          if (ready_busy_n_pin && rb_q_r)
            state_r <= ST_TR;
        end
        ST_TR: begin
          cnt_r <= cnt_r + 11'h001;
          if (cnt_r == TR_CYC[10:0]) begin
            nand_re_n_out <= 1'b0;
            cnt_r <= 11'h000;
            state_r <= ST_RSTROBE;
          end
        end
        ST_RSTROBE: begin
          nand_re_n_out <= 1'b0;
          cnt_r <= cnt_r + 11'h001;
          if (cnt_r == TSEQ_CYC[10:0]) begin
            rdata_r <= nand_io_in;
            nand_re_n_out <= 1'b1;
            cnt_r <= 11'h000;
            state_r <= ST_RHOLD;
          end
        end
        ST_RHOLD: begin
          cnt_r <= cnt_r + 11'h001;
          if (cnt_r == STROBE_CYC[10:0])
            state_r <= ST_DONE;
        end
        ST_DONE: begin
          avs_readdata_out <= {24'h0, rdata_r};
          state_r <= ST_ACK;
        end
        ST_ACK: begin
          avs_waitrequest_out <= 1'b0;
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule

// File: nfc_defs.vh
// Constants for the NAND flash host controller.
`ifndef NFC_DEFS_VH
`define NFC_DEFS_VH
`define NFC_REG_CTRL 4'h0
`define NFC_REG_CMD 4'h1
`define NFC_REG_ADDR 4'h2
`define NFC_REG_DATA 4'h3
`define NFC_REG_STAT 4'h4
`define NFC_REG_IRQ 4'h5
`define NFC_REG_MASK 4'h6
`define NFC_REG_CNT 4'h7
`define NFC_OP_CMD 3'h1
`define NFC_OP_ADDR 3'h2
`define NFC_OP_WDATA 3'h3
`define NFC_OP_RDATA 3'h4
`define NFC_PAGE_BYTES 528
`define NFC_PAGES_PER_BLOCK 16
`define NFC_BLOCKS 1024
`define NFC_SPARE_BLOCK_BYTES 256
`define NFC_CLK_NS 8
`define NFC_TR_NS 7000
`define NFC_TSEQ_NS 50
`define NFC_STROBE_CYC 3
`endif

// File: nfc_props.sv
// Protocol checker for the NAND flash host controller.
`timescale 1ns/10ps
module nfc_props (
  input wire mclk_in, nrst_in, avs_read_in, avs_waitrequest_out, nand_cle_out, nand_ale_out,
  input wire nand_ce_n_out, nand_we_n_out, nand_re_n_out, nand_io_oe_out,
  input wire [3:0] avs_address_in,
  input wire [7:0] nand_io_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  ack_one_cycle_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("ack held");
  latch_excl_a: assert property (!(nand_cle_out && nand_ale_out))
    else $error("both latches");
  strobe_excl_a: assert property (nand_we_n_out || nand_re_n_out)
    else $error("both strobes");
  write_drive_a: assert property (!nand_we_n_out |-> nand_io_oe_out)
    else $error("write undriven");
  read_free_a: assert property (!nand_re_n_out |-> !nand_io_oe_out)
    else $error("read driven");
  chip_sel_a: assert property (!(nand_we_n_out && nand_re_n_out) |-> !nand_ce_n_out)
    else $error("strobe unselected");
  data_hold_a: assert property (!nand_we_n_out ##1 !nand_we_n_out |-> $stable(nand_io_out))
    else $error("data moved");
  stat_ack_a: assert property (avs_read_in && avs_address_in == 4'h4 && avs_waitrequest_out |-> ##[1:3] !avs_waitrequest_out)
    else $error("slow status");
  cover property (!nand_re_n_out);
  cover property (nand_ale_out && !nand_we_n_out);
  cover property (avs_read_in && !avs_waitrequest_out);
endmodule
bind nfc_host nfc_props u_props (.*);

// File: nfc_flash_model.sv
// Behavioural NAND flash device facing the host controller.
`timescale 1ns/10ps
module nfc_flash_model #(parameter int BUSY_CYC = 200) (
  input wire logic nand_ce_n_out, nand_cle_out, nand_ale_out, nand_we_n_out, nand_re_n_out, nand_wp_n_out,
  input wire logic [7:0] nand_io_out,
  output logic [7:0] nand_io_in,
  output logic ready_busy_n_pin
);
  logic [7:0] mem [int], cmd = 8'hFF, pd = 8'hFF;
  logic [23:0] adr = 0;
  int left = 0;
  logic susp = 0;
  initial nand_io_in = 8'hFF;
  assign ready_busy_n_pin = left == 0 || susp;
  always #8 if (left > 0 && !susp) left--;
  // latch cycles, protected ones leave the array alone
  always @(posedge nand_we_n_out) if (!nand_ce_n_out) begin
    if (nand_ale_out) adr = {adr[15:0], nand_io_out};
    else if (!nand_cle_out) pd = nand_io_out;
    else if (nand_io_out == 8'hB0 || (susp && nand_io_out == 8'hD0)) susp = nand_io_out == 8'hB0;
    else begin
      cmd = nand_io_out;
      if (nand_wp_n_out && cmd == 8'h10) mem[adr] = pd;
      if (nand_wp_n_out && cmd == 8'hD0) foreach (mem[k]) if (k[23:12] == adr[15:4]) mem[k] = 8'hFF;
      if (nand_wp_n_out && (cmd == 8'h10 || cmd == 8'hD0)) left = BUSY_CYC;
    end
  end
  // status or array byte, and its inverse once the bus is released
  always @(negedge nand_re_n_out) if (!nand_ce_n_out) nand_io_in = cmd == 8'h70 ?
    {nand_wp_n_out, ready_busy_n_pin, susp, 5'h00} : mem.exists(adr) ? mem[adr] : 8'hFF;
  always @(posedge nand_re_n_out) nand_io_in = ~nand_io_in;
endmodule

// File: nfc_host_tb_top.sv
// Self-checking bench for the NAND flash host controller.
`timescale 1ns/10ps
module nfc_host_tb_top;
  logic mclk_in = 0, nrst_in = 0, avs_read_in = 0, avs_write_in = 0, avs_waitrequest_out, irq_out, ready_busy_n_pin;
  logic nand_io_oe_out, nand_cle_out, nand_ale_out, nand_ce_n_out, nand_we_n_out, nand_re_n_out, nand_wp_n_out;
  logic [3:0] avs_address_in = 0;
  logic [31:0] avs_writedata_in = 0, avs_readdata_out, rd;
  logic [7:0] nand_io_in, nand_io_out, b;
  logic [23:0] a;
  int n_mismatch = 0, comparisons = 0, cyc = 0;
  always #4 mclk_in = ~mclk_in;
  nfc_host u_dut (.*);
  nfc_flash_model u_mem (.*);
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] d);
    @(posedge mclk_in);
    avs_address_in <= ad;
    avs_writedata_in <= d;
    {avs_write_in, avs_read_in} <= {w, !w};
    do @(posedge mclk_in); while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out;
    {avs_write_in, avs_read_in} <= 2'b00;
  endtask
  task automatic op(input logic [7:0] c, input logic [23:0] ad, input int n);
    bus(1, 1, c);
    for (int i = n - 1; i >= 0; i--) bus(1, 2, ad[8*i +: 8]);
  endtask
  task automatic rdb(input logic [7:0] c, input logic [23:0] ad, input int n, input logic [7:0] e);
    op(c, ad, n);
    bus(0, 3, 0);
    chk(rd[7:0], e);
  endtask
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      complete_run;
    end
  end
  initial begin
    void'($urandom(32'h83549a3d));
    repeat (16) @(posedge mclk_in);
    nrst_in <= 1;
    bus(0, 7, 0);
    chk(rd, 528);
    bus(1, 6, 1);
    bus(1, 5, 7);
    for (int p = 1; p >= 0; p--) begin
      a = $urandom;
      b = $urandom;
      bus(1, 0, 4 | p);
      rdb(8'h70, 0, 0, {!p, 7'h40});
      chk(nand_wp_n_out, !p);
      chk(nand_ce_n_out, 0);
      op(8'h80, a, 3);
      bus(1, 3, b);
      bus(1, 1, 8'h10);
      if (!p) begin
        bus(1, 2, 0);
        bus(0, 5, 0);
        chk(rd[2], 1);
        do bus(0, 4, 0); while (rd[0] !== 1'b1);
      end
      chk(irq_out, !p);
      bus(1, 5, 7);
      bus(0, 6, 0);
      chk(rd, 1);
      chk(irq_out, 0);
      rdb(8'h00, a, 3, p ? 8'hFF : b);
      $display("program test done, protect %0d", p);
    end
    op(8'h60, a[23:8], 2);
    bus(1, 1, 8'hD0);
    bus(1, 1, 8'hB0);
    rdb(8'h70, 0, 0, 8'hE0);
    bus(1, 1, 8'hD0);
    do bus(0, 4, 0); while (rd[0] !== 1'b1);
    rdb(8'h00, a, 3, 8'hFF);
    $display("erase test done");
    bus(1, 0, 2);
    bus(0, 0, 0);
    chk(rd, 2);
    chk(nand_ce_n_out, 1);
    $display("standby test done");
    complete_run;
  end
endmodule
